/* logic/ees_defs.svh */
// Purpose: Constants of the serial EEPROM command sequencer.
// Assumes: Included by bare name from the design files.
// Notes: Holds offsets, field positions, codes, reset values and counts.
`ifndef EES_DEFS_SVH
`define EES_DEFS_SVH

// Upper opcode nibble is always zero; bit 3 is never decoded.
`define EES_OP_HI 4'h0
`define EES_OP_READ 3'h3
`define EES_OP_WRITE 3'h2
`define EES_OP_WRITE_ENABLE_CMD 3'h6
`define EES_OP_WRITE_DISABLE_CMD 3'h4
`define EES_OP_STATUS_READ_CMD 3'h5

// Array geometry: 8192 bytes, 32-byte pages, 16-bit address on the wire.
`define EES_ADDR_W 13
`define EES_MEM_BYTES 8192
`define EES_COL_W 5
`define EES_ROW_W 8
`define EES_PAGE_BYTES 32
`define EES_ADDR_LAST_BIT 4'hf

// Status byte fields and the all-ones value shown while programming.
`define EES_STAT_BUSY 0
`define EES_STAT_WEL 1
`define EES_STAT_BUSY_ALL 8'hff

// Program cycle length in system clock cycles (arbitrary plain default).
`define EES_PROG_CYCLES 2000

// Reset value of the sampled pin bundle: deselected, clock low.
`define EES_PIN_RST 5'h08

`endif

/* logic/ees_pkg.sv */
// Purpose: Types shared by the serial EEPROM command sequencer.
// Assumes: Used only through scoped names, never imported.
// Notes: Constants live in ees_defs.svh.
package ees_pkg;

    // Pins sampled from outside the clock domain, carried together.
    typedef struct packed {
        logic sck;
        logic cs_b;
        logic si;
        logic [1:0] prot;
    } ees_pins_t;

    // Command sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OPC,
        ST_ADDR,
        ST_RDATA,
        ST_WDATA,
        ST_STAT,
        ST_DROP
    } ees_state_t;

    // Latched single-byte commands that act when select is released.
    typedef enum logic [1:0] {
        ARM_NONE,
        ARM_WEL_SET,
        ARM_WEL_CLR
    } ees_arm_t;

endpackage

/* logic/ees_seq.sv */
// Purpose: Serial EEPROM slave: read, page write, enable latch and busy status.
// Assumes: Mode 0 link slower than a tenth of sys_clk_i; 8192-byte array.
// Notes: All link pins are sampled on sys_clk_i; clock and select are also edge-detected, data is not.
`timescale 1ns/10ps
`include "ees_defs.svh"

// How it works
// RL1: Read opcode then 16-bit address captured.
// RL2: Serial input ignored once read started.
// RL3: Addressed byte shifted out, MSB first.
// RL4: Read address increments after every byte.
// RL5: Read address wraps from top to zero.
// RL6: Master deselects after one byte for single.
// RL7: Programming needs write enable in prior selection.
// RL8: Protected addresses are never programmed.
// RL9: While programming only status read is served.
// RL10: Write opcode, 16-bit address, then data bytes.
// RL11: Program cycle starts on select release.
// RL12: Master releases select right after last bit.
// RL13: Status bit zero shows program in progress.
// RL14: Up to 32 bytes programmed as page.
// RL15: Only five low address bits increment.
// RL16: Extra bytes wrap and overwrite page data.
// RL17: Program completion clears write enable latch.
// RL18: Write without enable discarded until deselect.
// RL19: Fresh select fall needed after discard.
// RL20: Upper address bits above array are ignored.
// RL21: Opcodes eight bits, bit three ignored.
// RL22: Commands start on select fall, MSB first.
// RL23: Status bit one shows write enable latch.
module ees_seq #(
    parameter int unsigned PROG_CYCLES = `EES_PROG_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic spi_sck_i,
    input wire logic spi_cs_b_i,
    input wire logic spi_si_i,
    input wire logic [1:0] protect_level_i,
    output logic spi_so_o,
    output logic spi_so_oe_b_o,
    output logic busy_o,
    output logic write_en_o
);
    ees_pkg::ees_pins_t pin_raw; // Raw pins gathered into one bundle.
    ees_pkg::ees_pins_t pin_q; // Filtered pin levels.
    ees_pkg::ees_pins_t pin_p; // Filtered levels one cycle earlier.
    ees_pkg::ees_state_t st_q; // Sequencer state.
    ees_pkg::ees_arm_t arm_q; // Pending latch command.
    logic [3:0] cnt_q; // Bit counter within opcode, address or byte.
    logic [6:0] sh_q; // Serial input shift register.
    logic [14:0] adr_sh_q; // Address bits received so far.
    logic is_wr_q; // The address phase belongs to a write.
    logic [`EES_ADDR_W-1:0] rd_addr_q; // Read pointer.
    logic [6:0] osh_q; // Remaining bits of the byte being sent.
    logic [`EES_COL_W-1:0] col_q; // In-page column of the next write byte.
    logic [`EES_ROW_W-1:0] row_q; // Page held constant through a write.
    logic [`EES_PAGE_BYTES-1:0] mask_q; // Page bytes loaded this selection.
    logic seen_q; // At least one whole write byte arrived.
    logic busy_q; // Program cycle in progress.
    logic wel_q; // Write enable latch.
    logic [15:0] prog_cnt_q; // Cycles left in the program cycle.
    logic [5:0] idx_q; // Page byte being committed.
    logic [7:0] page_q [`EES_PAGE_BYTES]; // Page load buffer.
    logic [7:0] mem_q [`EES_MEM_BYTES]; // The array itself.
    logic sck_rise; // Rising clock edge while selected.
    logic sck_fall; // Falling clock edge while selected.
    logic cs_fall; // Start of a selection.
    logic cs_rise; // End of a selection.
    logic [7:0] in_byte; // Byte completed by the current input bit.
    logic [7:0] obyte; // Byte that the output shifter sends next.
    logic [7:0] stat_byte; // Status byte as seen by the master.
    logic op_ok; // Opcode upper nibble is zero.
    logic [2:0] op_code; // Decoded opcode bits, bit three dropped.
    logic prog_start; // Launch of a program cycle.
    logic mem_we; // Commit of one page byte.
    logic [`EES_ADDR_W-1:0] mem_wa; // Address of that byte.

    // Protection by level: none, top quarter, top half, whole array.
    function automatic logic prot_hit(input logic [1:0] lvl, input logic [12:0] a);
        logic hit;
        hit = 1'b0;
        unique case (lvl)
            2'h0: hit = 1'b0;
            2'h1: hit = (a[12:11] == 2'h3);
            2'h2: hit = a[12];
            2'h3: hit = 1'b1;
        endcase
        return hit;
    endfunction

    assign pin_raw = {spi_sck_i, spi_cs_b_i, spi_si_i, protect_level_i};

    // All pins cross through one three-stage synchroniser.
    ees_sync #(
        .W(5),
        .RST(`EES_PIN_RST)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .async_i(pin_raw),
        .level_o(pin_q)
    );

    // Previous filtered levels, used only for edge detection.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_p <= `EES_PIN_RST;
        end else begin
            pin_p <= pin_q;
        end
    end

    // Clock edges count only inside a selection.
    assign sck_rise = pin_q.sck & ~pin_p.sck & ~pin_q.cs_b;
    assign sck_fall = ~pin_q.sck & pin_p.sck & ~pin_q.cs_b;
    assign cs_fall = ~pin_q.cs_b & pin_p.cs_b;
    assign cs_rise = pin_q.cs_b & ~pin_p.cs_b;
    assign in_byte = {sh_q, pin_q.si};
    assign op_ok = (in_byte[7:4] == `EES_OP_HI); // [RL21]
    assign op_code = in_byte[2:0]; // [RL21]

    // Status: all ones while programming, else level, latch and ready.
    assign stat_byte = busy_q ? `EES_STAT_BUSY_ALL : {4'h0, pin_q.prot, wel_q, busy_q}; // [RL13] [RL23]
    assign obyte = (st_q == ees_pkg::ST_STAT) ? stat_byte : mem_q[rd_addr_q];

    // A program cycle needs a whole number of bytes; a torn last byte cancels the whole write.
    assign prog_start = cs_rise && st_q == ees_pkg::ST_WDATA && cnt_q == 4'h0 && seen_q
        && !busy_q; // [RL11] [RL12]

    // Command sequencer; every selection restarts it and deselect ends it.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= ees_pkg::ST_IDLE;
            arm_q <= ees_pkg::ARM_NONE;
            cnt_q <= 4'h0;
            sh_q <= 7'h00;
            adr_sh_q <= 15'h0000;
            is_wr_q <= 1'b0;
        end else if (pin_q.cs_b) begin
            // Deselected: back to standby, pending latch commands are spent.
            st_q <= ees_pkg::ST_IDLE; // [RL18] [RL19]
            arm_q <= ees_pkg::ARM_NONE;
            cnt_q <= 4'h0;
        end else if (cs_fall) begin
            st_q <= ees_pkg::ST_OPC; // [RL22]
            cnt_q <= 4'h0;
        end else if (sck_rise) begin
            sh_q <= in_byte[6:0];
            unique case (st_q)
                ees_pkg::ST_OPC: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == 4'h7) begin
                        cnt_q <= 4'h0;
                        if (busy_q && !(op_ok && op_code == `EES_OP_STATUS_READ_CMD)) begin
                            st_q <= ees_pkg::ST_DROP; // [RL9]
                        end else if (!op_ok) begin
                            st_q <= ees_pkg::ST_DROP;
                        end else if (op_code == `EES_OP_STATUS_READ_CMD) begin
                            st_q <= ees_pkg::ST_STAT; // [RL9]
                        end else if (op_code == `EES_OP_READ) begin
                            st_q <= ees_pkg::ST_ADDR; // [RL1]
                            is_wr_q <= 1'b0;
                        end else if (op_code == `EES_OP_WRITE) begin
                            // Without the latch the write is swallowed whole.
                            st_q <= wel_q ? ees_pkg::ST_ADDR : ees_pkg::ST_DROP; // [RL7] [RL18]
                            is_wr_q <= 1'b1; // [RL10]
                        end else if (op_code == `EES_OP_WRITE_ENABLE_CMD) begin
                            st_q <= ees_pkg::ST_DROP;
                            arm_q <= ees_pkg::ARM_WEL_SET; // [RL7]
                        end else if (op_code == `EES_OP_WRITE_DISABLE_CMD) begin
                            st_q <= ees_pkg::ST_DROP;
                            arm_q <= ees_pkg::ARM_WEL_CLR;
                        end else begin
                            st_q <= ees_pkg::ST_DROP;
                        end
                    end
                end
                ees_pkg::ST_ADDR: begin
                    adr_sh_q <= {adr_sh_q[13:0], pin_q.si}; // [RL1] [RL22]
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == `EES_ADDR_LAST_BIT) begin
                        cnt_q <= 4'h0;
                        st_q <= is_wr_q ? ees_pkg::ST_WDATA : ees_pkg::ST_RDATA;
                    end
                end
                ees_pkg::ST_WDATA: begin
                    cnt_q <= {1'b0, cnt_q[2:0] + 3'h1}; // [RL10]
                end
                ees_pkg::ST_DROP: begin
                    // Trailing clocks void a latch command.
                    arm_q <= ees_pkg::ARM_NONE;
                end
                default: begin
                    // Read and status phases ignore the input line.
                    st_q <= st_q; // [RL2]
                end
            endcase
        end else if (sck_fall && (st_q == ees_pkg::ST_RDATA || st_q == ees_pkg::ST_STAT)) begin
            cnt_q <= {1'b0, cnt_q[2:0] + 3'h1};
        end
    end

    // Output shifter; data changes on falling clock edges, MSB first.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            spi_so_o <= 1'b0;
            spi_so_oe_b_o <= 1'b1;
            osh_q <= 7'h00;
        end else if (pin_q.cs_b) begin
            spi_so_oe_b_o <= 1'b1;
        end else if (sck_fall && (st_q == ees_pkg::ST_RDATA || st_q == ees_pkg::ST_STAT)) begin
            spi_so_oe_b_o <= 1'b0;
            if (cnt_q[2:0] == 3'h0) begin
                spi_so_o <= obyte[7]; // [RL3]
                osh_q <= obyte[6:0];
            end else begin
                spi_so_o <= osh_q[6]; // [RL3]
                osh_q <= {osh_q[5:0], 1'b0};
            end
        end
    end

    // Read pointer: loaded from the address, stepped after each byte sent.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_addr_q <= '0;
        end else if (sck_rise && st_q == ees_pkg::ST_ADDR && cnt_q == `EES_ADDR_LAST_BIT) begin
            rd_addr_q <= {adr_sh_q[11:0], pin_q.si}; // [RL1] [RL20]
        end else if (sck_fall && st_q == ees_pkg::ST_RDATA && cnt_q[2:0] == 3'h7) begin
            // The pointer is exactly the array width, so it wraps to zero.
            rd_addr_q <= rd_addr_q + 13'h0001; // [RL4] [RL5]
        end
    end

    // Page load: column, page and loaded-byte mask.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            col_q <= '0;
            row_q <= '0;
            mask_q <= '0;
            seen_q <= 1'b0;
        end else if (cs_fall && !busy_q) begin
            // A status poll early in a program cycle must not wipe the mask
            // while the page is still being committed; no write loads then.
            mask_q <= '0;
            seen_q <= 1'b0;
        end else if (sck_rise && st_q == ees_pkg::ST_ADDR && cnt_q == `EES_ADDR_LAST_BIT) begin
            col_q <= {adr_sh_q[3:0], pin_q.si}; // [RL20]
            row_q <= adr_sh_q[11:4];
        end else if (sck_rise && st_q == ees_pkg::ST_WDATA && cnt_q[2:0] == 3'h7) begin
            mask_q[col_q] <= 1'b1; // [RL14]
            seen_q <= 1'b1;
            // Only the column steps; it wraps inside the page.
            col_q <= col_q + 5'h01; // [RL15] [RL16]
        end
    end

    // Page buffer data; a repeated column simply overwrites.
    always_ff @(posedge sys_clk_i) begin
        if (sck_rise && st_q == ees_pkg::ST_WDATA && cnt_q[2:0] == 3'h7) begin
            page_q[col_q] <= in_byte; // [RL16]
        end
    end

    // Program cycle and write enable latch share one owner.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_q <= 1'b0;
            wel_q <= 1'b0;
            prog_cnt_q <= 16'h0000;
            idx_q <= 6'h00;
        end else if (busy_q) begin
            if (idx_q != 6'h20) begin
                idx_q <= idx_q + 6'h01;
            end
            prog_cnt_q <= prog_cnt_q - 16'h0001;
            if (prog_cnt_q == 16'h0000) begin
                busy_q <= 1'b0;
                wel_q <= 1'b0; // [RL17]
            end
        end else if (prog_start) begin
            busy_q <= 1'b1; // [RL11] [RL14]
            prog_cnt_q <= 16'(PROG_CYCLES - 1);
            idx_q <= 6'h00;
        end else if (cs_rise && arm_q == ees_pkg::ARM_WEL_SET) begin
            wel_q <= 1'b1; // [RL7]
        end else if (cs_rise && arm_q == ees_pkg::ARM_WEL_CLR) begin
            wel_q <= 1'b0;
        end
    end

    // One page byte is committed per cycle early in the program cycle.
    assign mem_wa = {row_q, idx_q[4:0]};
    assign mem_we = busy_q && idx_q != 6'h20 && mask_q[idx_q[4:0]]
        && !prot_hit(pin_q.prot, mem_wa); // [RL8]

    // The array; it has no reset, as real cells keep their contents.
    always_ff @(posedge sys_clk_i) begin
        if (mem_we) begin
            mem_q[mem_wa] <= page_q[idx_q[4:0]];
        end
    end

    assign busy_o = busy_q;
    assign write_en_o = wel_q;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_prog_needs_wel: assert property ($rose(busy_q) |-> $past(wel_q) && $past(cs_rise)) // [RL7]
        else $error("program cycle began without latch or deselect");
    a_prot_no_write: assert property (mem_we |-> pin_q.prot == 2'h0 // [RL8]
        || (pin_q.prot == 2'h1 && mem_wa < 13'h1800) || (pin_q.prot == 2'h2 && mem_wa < 13'h1000))
        else $error("protected byte was programmed");
    a_busy_drops_cmd: assert property (busy_q && sck_rise && st_q == ees_pkg::ST_OPC // [RL9]
        && cnt_q == 4'h7 && !(op_ok && op_code == `EES_OP_STATUS_READ_CMD)
        |=> st_q == ees_pkg::ST_DROP)
        else $error("command served while programming");
    a_busy_status_ff: assert property (busy_q && sck_fall && st_q == ees_pkg::ST_STAT // [RL13]
        |=> spi_so_o)
        else $error("status does not show busy");
    a_busy_holds: assert property ($rose(busy_q) |-> busy_q [*8]) // [RL11]
        else $error("program cycle ended too early");
    a_wel_clears: assert property ($fell(busy_q) |-> !wel_q) // [RL17]
        else $error("latch survived program cycle");
    a_nowel_discard: assert property (sck_rise && st_q == ees_pkg::ST_OPC && cnt_q == 4'h7 // [RL18]
        && op_ok && op_code == `EES_OP_WRITE && !wel_q |=> st_q == ees_pkg::ST_DROP ##1 !busy_q)
        else $error("write accepted without latch");
    a_col_wrap: assert property (sck_rise && st_q == ees_pkg::ST_WDATA && cnt_q == 4'h7 // [RL15]
        |=> col_q == 5'($past(col_q) + 5'h01) && $stable(row_q))
        else $error("page column step wrong");
    a_read_incr: assert property (sck_fall && st_q == ees_pkg::ST_RDATA && cnt_q == 4'h7 // [RL4]
        |=> rd_addr_q == 13'($past(rd_addr_q) + 13'h0001))
        else $error("read pointer did not step");
    a_msb_first: assert property (sck_fall && st_q == ees_pkg::ST_RDATA && cnt_q == 4'h0 // [RL3]
        |=> spi_so_o == $past(obyte[7]) && !spi_so_oe_b_o)
        else $error("first bit out is not the MSB");
    a_si_ignored: assert property (sck_rise && st_q == ees_pkg::ST_RDATA // [RL2]
        |=> st_q == ees_pkg::ST_RDATA && $stable(cnt_q))
        else $error("read reacted to serial input");
endmodule

/* logic/ees_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter for slow pins.
// Assumes: Inputs are asynchronous to sys_clk_i.
// Notes: A bit changes only once the second and third stages agree.
`timescale 1ns/10ps
module ees_sync #(
    parameter int W = 5,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] level_o
);
    logic [W-1:0] s1_q; // First stage, read only by the second.
    logic [W-1:0] s2_q; // Second stage.
    logic [W-1:0] s3_q; // Third stage.

    // Shift chain; the reset value keeps the link deselected.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_q <= RST;
            s2_q <= RST;
            s3_q <= RST;
        end else begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Filtered level: a bit follows only where stages two and three agree.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            level_o <= RST;
        end else begin
            level_o <= (s2_q & ~(s2_q ^ s3_q)) | (level_o & (s2_q ^ s3_q));
        end
    end
endmodule

/* test/ees_spi_master.sv */
// Purpose: Behavioural serial master that drives the sequencer link pins.
// Assumes: Mode 0, clock idle low, 125 ns serial clock period.
// Notes: The clock stands still between frames; the data line flips when idle.
`timescale 1ns/10ps
module ees_spi_master (
    output logic sck_o,
    output logic cs_b_o,
    output logic si_o,
    input wire logic so_i
);
    // Start deselected with the clock parked low.
    initial begin
        sck_o = 1'b0;
        cs_b_o = 1'b1;
        si_o = 1'b0;
    end

    // Every command opens on a fresh falling select.
    task automatic sel();
        cs_b_o = 1'b0;
        #100;
    endtask

    // One byte, MSB first; so is taken at the end of each low phase.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si_o = tx[i];
            #62.5;
            rx[i] = so_i;
            sck_o = 1'b1;
            #62.5;
            sck_o = 1'b0;
        end
    endtask

    // Select rises in the low phase right after the last bit.
    task automatic desel();
        #20;
        cs_b_o = 1'b1;
        si_o = ~si_o;
        #100;
    endtask
endmodule

/* test/test_ees_seq.sv */
// Purpose: Self-checking bench for the serial EEPROM command sequencer.
// Assumes: A short program cycle of 1000 clocks keeps the run brief.
// Notes: Expected bytes follow from the page and wrap behaviour alone.
`timescale 1ns/10ps
module test_ees_seq;
    logic sys_clk = 1'b0; // System clock, 100 MHz.
    logic rst_b = 1'b0; // Asynchronous reset, active low.
    logic [1:0] prot = 2'h0; // Protection level presented to the design.
    logic sck, cs_b, si, so, so_oe_b, busy, wen;
    logic [2:0] flags; // Output-enable, latch and busy seen together.
    int error_cnt = 0;
    int n_tests = 0;

    assign flags = {so_oe_b, wen, busy};

    // Half period of 5 ns gives 100 MHz.
    always #5 sys_clk = ~sys_clk;

    ees_seq #(.PROG_CYCLES(1000)) dut_u (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
        .spi_sck_i(sck), .spi_cs_b_i(cs_b), .spi_si_i(si), .protect_level_i(prot),
        .spi_so_o(so), .spi_so_oe_b_o(so_oe_b), .busy_o(busy), .write_en_o(wen));
    // A released data line shows the inverse of its last value to the master.
    ees_spi_master m_u (.sck_o(sck), .cs_b_o(cs_b), .si_o(si), .so_i(so_oe_b ? ~so : so));

    // Counts a comparison and reports a mismatch at once.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Flags are read mid-cycle so that no clock edge races the sample.
    task automatic fl(input logic [2:0] mask, input logic [2:0] exp);
        @(negedge sys_clk);
        chk({5'h00, flags & mask}, {5'h00, exp});
    endtask

    // Bounded wait for the program cycle to end.
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 2000) begin
            @(posedge sys_clk);
            n++;
        end
        chk({7'h00, busy}, 8'h00);
    endtask

    // Changes protection off the link and lets the synchroniser settle.
    task automatic set_prot(input logic [1:0] p);
        @(posedge sys_clk);
        prot <= p;
        repeat (10) @(posedge sys_clk);
    endtask

    // Status read with bit 3 of the opcode set; compares the second byte.
    task automatic stat(input logic [7:0] exp);
        logic [7:0] rx;
        m_u.sel();
        m_u.xfer(8'h0d, rx);
        m_u.xfer(8'h00, rx);
        m_u.desel();
        chk(rx, exp);
    endtask

    // Latch-setting command alone in its selection.
    task automatic wr_enable();
        logic [7:0] rx;
        m_u.sel();
        m_u.xfer(8'h06, rx);
        m_u.desel();
    endtask

    // Write with bit 3 set; select is left low so the caller decides the release.
    task automatic wr(input logic [15:0] a, input int n, input logic [7:0] b,
        input logic [7:0] s);
        logic [7:0] rx;
        m_u.sel();
        m_u.xfer(8'h0a, rx);
        m_u.xfer(a[15:8], rx);
        m_u.xfer(a[7:0], rx);
        for (int k = 0; k < n; k++) begin
            m_u.xfer(b + 8'(k) * s, rx);
        end
    endtask

    // Streams n bytes while sending a write opcode on si as noise.
    task automatic rd(input logic [15:0] a, input int n, input logic [31:0] exp);
        logic [7:0] rx;
        m_u.sel();
        m_u.xfer(8'h03, rx);
        m_u.xfer(a[15:8], rx);
        m_u.xfer(a[7:0], rx);
        for (int k = 0; k < n; k++) begin
            m_u.xfer(8'h02, rx);
            chk(rx, exp[31 - 8 * k -: 8]);
        end
        m_u.desel();
    endtask

    // Idle status shows only the protection level for every level.
    task automatic t_status();
        for (int p = 0; p < 4; p++) begin
            set_prot(2'(p));
            stat({4'h0, 2'(p), 2'b00});
        end
        set_prot(2'h0);
        $display("status test done");
    endtask

    // 33 bytes into page zero: the last one lands on column zero again.
    task automatic t_page();
        wr_enable();
        fl(3'b010, 3'b010);
        stat(8'h02);
        wr(16'he000, 33, 8'h80, 8'h01);
        fl(3'b001, 3'b000);
        m_u.desel();
        fl(3'b001, 3'b001);
        stat(8'hff);
        wait_idle();
        fl(3'b010, 3'b000);
        stat(8'h00);
        $display("page test done");
    endtask

    // Column wrap at the array top, then commands sent while programming.
    task automatic t_busy();
        logic [7:0] rx;
        wr_enable();
        wr(16'h1ffe, 3, 8'h44, 8'h11);
        m_u.desel();
        wr_enable();
        m_u.sel();
        for (int k = 0; k < 4; k++) begin
            m_u.xfer(8'h03 & {8{k == 0}}, rx);
        end
        fl(3'b100, 3'b100);
        m_u.desel();
        wait_idle();
        fl(3'b010, 3'b000);
        $display("busy test done");
    endtask

    // Streaming read across the top of the array and single-byte reads.
    task automatic t_read();
        rd(16'hfffe, 4, 32'h4455a081);
        rd(16'h1fe0, 1, 32'h66000000);
        rd(16'h001f, 1, 32'h9f000000);
        $display("read test done");
    endtask

    // A write without the latch is dropped; the next selection still works.
    task automatic t_no_wen();
        wr(16'h0000, 1, 8'h5a, 8'h00);
        m_u.desel();
        fl(3'b011, 3'b000);
        rd(16'h0000, 1, 32'ha0000000);
        $display("no-enable test done");
    endtask

    // With the whole array protected the stored byte must survive.
    task automatic t_protect();
        set_prot(2'h3);
        wr_enable();
        wr(16'h0001, 1, 8'h77, 8'h00);
        m_u.desel();
        wait_idle();
        set_prot(2'h0);
        rd(16'h0001, 1, 32'h81000000);
        $display("protect test done");
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence: reset for three cycles, then each scenario in turn.
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (10) @(posedge sys_clk);
        t_status();
        t_page();
        t_busy();
        t_read();
        t_no_wen();
        t_protect();
        complete_run();
    end

    // Watchdog: the scenarios need about 120 us, so 500 us means a hang.
    initial begin
        #500000;
        error_cnt++;
        complete_run();
    end
endmodule
